// >>> bench/llsf_pd_model.sv
// Behavioural detector front end: sample pulses, X/Y pairs and period slot pulses.
`timescale 1ns/1ns
module llsf_pd_model import llsf_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	output logic in_valid_o,
	output llsf_xy_t pd_o,
	output logic slot_o
);
	// ======================================================================
	// Samples every third cycle, slots every fifth; the data lines toggle between samples.
	int pseed = 70512;
	logic [3:0] cnt;
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt <= 4'h0;
			in_valid_o <= 1'b0;
			slot_o <= 1'b0;
			pd_o <= '0;
		end else begin
			cnt <= (cnt == 4'hE) ? 4'h0 : cnt + 4'h1;
			in_valid_o <= (cnt % 3 == 0);
			slot_o <= (cnt % 5 == 0);
			pd_o <= (cnt % 3 == 0) ? llsf_xy_t'($random(pseed)) : ~pd_o;
		end
	end
endmodule

// >>> bench/llsf_top_properties.sv
// Port-level checks on the lock-in output filter top.
`timescale 1ns/1ns
module llsf_top_properties import llsf_pkg::*; #(
	parameter int TRACE_DIV = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire llsf_av_req_t av_req_i,
	input wire logic av_waitrequest_o,
	input wire logic [7:0] res_min_i,
	input wire logic [7:0] res_max_i,
	input wire logic in_valid_i,
	input wire logic slot_i,
	input wire llsf_xy_t trace_o,
	input wire logic xy_valid_o,
	input wire logic sync_on_o,
	input wire logic [4:0] tc_o,
	input wire logic [7:0] reserve_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// ======================================================================
	// Helpers: settling count after reset and spacing of trace snapshots.
	logic req_any;
	logic [1:0] up;
	logic [15:0] gap;
	llsf_xy_t last;
	assign req_any = av_req_i.read | av_req_i.write;

	// Gap stays zero until the first snapshot, so reset never looks like a short period.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			up <= 2'h0;
			gap <= 16'h0000;
			last <= '0;
		end else begin
			last <= trace_o;
			if (up != 2'h3) up <= up + 2'h1;
			if (trace_o != last) gap <= 16'h0001;
			else if (gap != 16'h0000 && gap != 16'hFFFF) gap <= gap + 16'h0001;
		end
	end

	// ======================================================================
	// Bus handshake: exactly one wait state, none while idle.
	sequence s_one_wait;
		av_waitrequest_o ##1 !av_waitrequest_o;
	endsequence
	a_bus_wait: assert property ($rose(req_any) |-> s_one_wait)
		else $error("bus answer not after exactly one wait state");
	a_idle_free: assert property (!req_any |-> !av_waitrequest_o)
		else $error("waitrequest high with no request");

	// ======================================================================
	// Settings limits.
	a_res_bounds: assert property (up == 2'h3 |-> reserve_o >= $past(res_min_i) && reserve_o <= $past(res_max_i))
		else $error("reserve outside its limits");
	a_tc_ceiling: assert property (tc_o <= 5'h13)
		else $error("time constant above the longest setting");

	// ======================================================================
	// Stream timing of the pole chain, the period filter and the trace output.
	a_fast_path: assert property (in_valid_i && !sync_on_o |-> ##[4:5] (xy_valid_o || sync_on_o))
		else $error("sample did not reach the output");
	a_valid_cause: assert property (xy_valid_o && !sync_on_o && !$past(sync_on_o, 6)
		|-> $past(in_valid_i, 4) || $past(in_valid_i, 5))
		else $error("output without a detector sample");
	a_sync_slot: assert property (xy_valid_o && sync_on_o && $past(sync_on_o, 6)
		|-> $past(slot_i, 2) || $past(slot_i, 3) || $past(slot_i, 4) || $past(slot_i, 5))
		else $error("synchronous output not paced by slots");
	a_trace_rate: assert property (trace_o != last && gap != 16'h0000 |-> gap >= TRACE_DIV)
		else $error("trace refreshed too early");
endmodule

bind llsf_top llsf_top_properties #(.TRACE_DIV(TRACE_DIV)) u_props (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .av_req_i(av_req_i), .av_waitrequest_o(av_waitrequest_o),
	.res_min_i(res_min_i), .res_max_i(res_max_i), .in_valid_i(in_valid_i), .slot_i(slot_i),
	.trace_o(trace_o), .xy_valid_o(xy_valid_o), .sync_on_o(sync_on_o), .tc_o(tc_o), .reserve_o(reserve_o)
);

// >>> bench/tb_top.sv
// Bench for the lock-in output filter top, checked against a reference model.
`timescale 1ns/1ns
`include "llsf_defs.svh"
module tb_top import llsf_pkg::*;;
	// ======================================================================
	// Port signals, counters and model state.
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	llsf_av_req_t req = '0;
	logic av_waitrequest_o, in_valid_i, slot_i, xy_valid_o, sync_on_o, sens_chg_i = 1'b0;
	logic [31:0] av_readdata_o, q;
	logic [23:0] ref_freq_i = 24'h00_03E8;
	logic [7:0] res_min_i = 8'h0A;
	logic [7:0] res_max_i = 8'h3C;
	logic [7:0] res_safe_i = 8'h1E;
	logic [7:0] reserve_o;
	logic [4:0] tc_o;
	logic [15:0] mag_o;
	llsf_xy_t phase_detector_i, xy_o, trace_o;
	int error_cnt = 0;
	int n_tests = 0;
	int seed = 70512;
	int mode = 0, res = 0, lmin = 10, lmax = 60, tc = 8, slope = 0, sy = 0, harm = 1, xe = 0, ye = 0, hi = 0, f;
	int bt[4] = '{45, 55, 62, 72};
	int nt[4] = '{13, 6, 4, 3};
	int rv[5] = '{45, 70, 0, 10, 40};

	// The clock toggles every 20 ns, half of its 40 ns period.
	always #20 clk_i = ~clk_i;

	llsf_top #(.TRACE_DIV(8)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .av_req_i(req),
		.av_waitrequest_o(av_waitrequest_o), .av_readdata_o(av_readdata_o), .ref_freq_i(ref_freq_i),
		.res_min_i(res_min_i), .res_max_i(res_max_i), .sens_chg_i(sens_chg_i), .res_safe_i(res_safe_i),
		.in_valid_i(in_valid_i), .phase_detector_i(phase_detector_i), .slot_i(slot_i), .xy_o(xy_o),
		.xy_valid_o(xy_valid_o), .trace_o(trace_o), .mag_o(mag_o), .sync_on_o(sync_on_o), .tc_o(tc_o),
		.reserve_o(reserve_o));
	llsf_pd_model u_pd (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .in_valid_o(in_valid_i),
		.pd_o(phase_detector_i), .slot_o(slot_i));

	// ======================================================================
	// Reference model of the settings logic.
	function automatic int eff();
		return mode == 0 ? lmax : mode == 1 ? lmin : res;
	endfunction
	function automatic int gain();
		return eff() + (xe > ye ? xe : ye);
	endfunction
	function automatic int mint(input int g);
		int k;
		k = g < bt[slope] ? 0 : (g - bt[slope]) / (10 * slope + 10) + 1;
		return k > nt[slope] ? nt[slope] : k;
	endfunction
	function automatic void settle();
		if (tc < mint(gain())) tc = mint(gain());
		if (hi && tc > 13) tc = 13;
	endfunction
	function automatic void rng();
		int d;
		d = ref_freq_i * harm;
		if (d > `LLSF_FREQ_UP) hi = 1;
		else if (d < `LLSF_FREQ_DN) hi = 0;
		settle();
	endfunction

	// ======================================================================
	// Comparison, bus cycles and model-tracked writes.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// The request stands until the rising edge that samples waitrequest low; read data is taken at that edge.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req.read <= !w;
		req.write <= w;
		req.address <= a;
		req.writedata <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (av_waitrequest_o !== 1'b0 && n < 50);
		q = av_readdata_o;
		if (n >= 50) error_cnt++;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	task automatic verify();
		rd(`LLSF_REG_STAT);
		chk(q, {7'h00, 9'(gain()), 8'(eff()), 1'b0, 5'(mint(gain())), (sy && !hi), hi[0]});
		chk({tc_o, reserve_o, sync_on_o}, {5'(tc), 8'(eff()), (sy && !hi)});
	endtask
	task automatic ctrl(input int v);
		if (v % 4 != 3) mode = v % 4;
		slope = v / 4 % 4;
		sy = v / 16 % 2;
		if (v / 256 % 2) begin
			mode = 2;
			res = res_safe_i < lmin ? lmin : res_safe_i > lmax ? lmax : res_safe_i;
		end
		settle();
		bus(1'b1, `LLSF_REG_CTRL, 32'(v));
	endtask
	task automatic resw(input int v);
		if (mode == 2 && v >= lmin && v <= lmax && (v - lmin) % 10 == 0) res = v;
		settle();
		bus(1'b1, `LLSF_REG_RES, 32'(v));
	endtask
	task automatic tcw(input int v);
		if (v >= mint(gain()) && v <= (hi ? 13 : 19)) tc = v;
		bus(1'b1, `LLSF_REG_TC, 32'(v));
	endtask
	task automatic expw(input int x, input int y);
		int ox, oy;
		ox = xe;
		oy = ye;
		xe = x;
		ye = y;
		if ((x > ox || y > oy) && mint(gain()) > tc) begin
			xe = ox;
			ye = oy;
		end
		bus(1'b1, `LLSF_REG_EXP, {16'h0000, 8'(y), 8'(x)});
	endtask
	task automatic sens(input int mn, input int mx);
		@(posedge clk_i);
		res_min_i <= 8'(mn);
		res_max_i <= 8'(mx);
		sens_chg_i <= 1'b1;
		@(posedge clk_i);
		sens_chg_i <= 1'b0;
		if (mode == 2) res = mn + res - lmin > mx ? mx : mn + res - lmin;
		lmin = mn;
		lmax = mx;
		settle();
	endtask
	task automatic freq(input int v);
		@(posedge clk_i);
		ref_freq_i <= 24'(v);
		@(posedge clk_i);
		rng();
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Each slow refresh must hold the fast output of the cycle before and its magnitude estimate.
	llsf_xy_t xy_q, tr_q;
	int ma, mb;
	always @(posedge clk_i) begin
		if (!sys_rst_i && trace_o != tr_q) begin
			ma = trace_o.x;
			mb = trace_o.y;
			ma = ma < 0 ? -ma : ma;
			mb = mb < 0 ? -mb : mb;
			chk(trace_o, xy_q);
			chk(mag_o, ma > mb ? ma + mb / 2 : mb + ma / 2);
		end
		xy_q <= xy_o;
		tr_q <= trace_o;
	end

	// Watchdog: the scenarios need a few thousand cycles at most.
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		close_out();
	end

	// ======================================================================
	// Scenarios.
	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(`LLSF_REG_TC);
		chk(q, 32'h0000_0008);
		verify();
		resw(20);
		verify();
		ctrl(1);
		ctrl(3);
		verify();
		ctrl(256);
		verify();
		rd(`LLSF_REG_CTRL);
		chk(q, 32'h0000_0002);
		foreach (rv[i]) begin
			resw(rv[i]);
			verify();
		end
		sens(20, 40);
		verify();
		sens(6, 66);
		verify();
		@(posedge clk_i);
		res_safe_i <= 8'h64;
		@(posedge clk_i);
		ctrl(256);
		verify();
		// Random gains across every slope, with time constant writes at and below the floor.
		for (int s = 0; s < 4; s++) begin
			ctrl(s * 4);
			repeat (4) begin
				f = $unsigned($random(seed)) % 191;
				sens(f / 2, f);
				verify();
				tcw(mint(gain()) - 1);
				tcw(mint(gain()));
				verify();
			end
		end
		sens(0, 0);
		tcw(20);
		tcw(32);
		tcw(19);
		verify();
		freq(`LLSF_FREQ_UP + 1);
		verify();
		tcw(14);
		freq(`LLSF_FREQ_DN);
		verify();
		freq(`LLSF_FREQ_DN - 1);
		verify();
		tcw(19);
		bus(1'b1, `LLSF_REG_HARM, 32'h0000_0000);
		bus(1'b1, `LLSF_REG_HARM, 32'h0000_0002);
		harm = 2;
		rng();
		verify();
		rd(`LLSF_REG_HARM);
		chk(q, 32'(harm));
		freq(`LLSF_FREQ_UP / 2 + 1);
		verify();
		freq(1000);
		// Expand raise against a short time constant, then a legal raise.
		ctrl(0);
		sens(10, 60);
		tcw(2);
		expw(20, 0);
		verify();
		tcw(10);
		expw(20, 10);
		rd(`LLSF_REG_EXP);
		chk(q, {16'h0000, 8'(ye), 8'(xe)});
		verify();
		expw(0, 0);
		// Period filter with hysteresis on the doubled frequency.
		ctrl(16);
		verify();
		repeat (700) @(posedge clk_i);
		freq(`LLSF_FREQ_UP / 2 + 1);
		verify();
		freq(`LLSF_FREQ_DN / 2);
		verify();
		freq(`LLSF_FREQ_DN / 2 - 1);
		verify();
		bus(1'b1, `LLSF_REG_STAT, 32'hFFFF_FFFF);
		verify();
		rd(5'h1E);
		chk(q, 32'h0000_0000);
		close_out();
	end
endmodule

// >>> rtl/llsf_pole.sv
// One first-order low-pass pole acting on an X/Y pair.
`timescale 1ns/1ns
module llsf_pole import llsf_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic valid_i,
	input wire logic [4:0] shift_i,
	input wire llsf_xy_t din_i,
	output logic valid_o,
	output llsf_xy_t dout_o
);

	llsf_pole_st_t s;
	llsf_pole_st_t next_s;

	// Move the accumulator a power-of-two fraction toward the input.
	function automatic logic signed [39:0] step(input logic signed [39:0] acc, input logic signed [15:0] din,
		input logic [4:0] sh);
		logic signed [39:0] d;
		d = $signed({din, 24'h00_0000}) - acc;
		step = acc + (d >>> sh);
	endfunction

	// ======================================================================
	// Update on each valid sample; the shift sets the time constant.
	always_comb begin
		next_s = s;
		next_s.v = valid_i;
		if (valid_i) begin
			next_s.ax = step(s.ax, din_i.x, shift_i);
			next_s.ay = step(s.ay, din_i.y, shift_i);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign valid_o = s.v;
	assign dout_o = '{x: s.ax[39:24], y: s.ay[39:24]};

endmodule

// >>> rtl/llsf_top.sv
// Lock-in output low-pass chain with reserve, time constant and synchronous filter control.
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
`include "llsf_defs.svh"
module llsf_top import llsf_pkg::*; #(
	parameter int TRACE_DIV = `LLSF_CLK_HZ / `LLSF_TRACE_HZ
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire llsf_av_req_t av_req_i,
	output logic av_waitrequest_o,
	output logic [31:0] av_readdata_o,
	input wire logic [23:0] ref_freq_i,
	input wire logic [7:0] res_min_i,
	input wire logic [7:0] res_max_i,
	input wire logic sens_chg_i,
	input wire logic [7:0] res_safe_i,
	input wire logic in_valid_i,
	input wire llsf_xy_t phase_detector_i,
	input wire logic slot_i,
	output llsf_xy_t xy_o,
	output logic xy_valid_o,
	output llsf_xy_t trace_o,
	output logic [15:0] mag_o,
	output logic sync_on_o,
	output logic [4:0] tc_o,
	output logic [7:0] reserve_o
);

	// ======================================================================
	// Parameter check
	generate
		if (TRACE_DIV < 2) begin : g_bad_div
			$error("TRACE_DIV must be at least 2");
		end
	endgenerate

	localparam logic [31:0] DIV_LAST = 32'(TRACE_DIV - 1);

	llsf_state_t s;
	llsf_state_t next_s;

	// ======================================================================
	// Helper functions

	// Ladder index of the least time constant for a gain and slope.
	function automatic logic [4:0] min_tc(input logic [8:0] gain, input logic [1:0] slope);
		logic [8:0] thr;
		logic [8:0] stp;
		logic [4:0] n;
		logic [4:0] cnt;
		thr = `LLSF_MT1_BASE;
		stp = `LLSF_MT1_STEP;
		n = `LLSF_MT1_N;
		cnt = 5'h00;
		unique case (slope)
			2'h0: begin
				thr = `LLSF_MT1_BASE;
				stp = `LLSF_MT1_STEP;
				n = `LLSF_MT1_N;
			end
			2'h1: begin
				thr = `LLSF_MT2_BASE;
				stp = `LLSF_MT2_STEP;
				n = `LLSF_MT2_N;
			end
			2'h2: begin
				thr = `LLSF_MT3_BASE;
				stp = `LLSF_MT3_STEP;
				n = `LLSF_MT3_N;
			end
			2'h3: begin
				thr = `LLSF_MT4_BASE;
				stp = `LLSF_MT4_STEP;
				n = `LLSF_MT4_N;
			end
		endcase
		// Count thresholds at or below the gain; gains past the table keep the last entry.
		for (int i = 0; i < 13; i++) begin
			if (5'(i) < n && gain >= thr) begin
				cnt = 5'(i + 1);
			end
			thr = thr + stp;
		end
		min_tc = cnt;
	endfunction

	// Coefficient shift for a ladder index, roughly log2 of the time constant.
	function automatic logic [4:0] shift_of(input logic [4:0] idx);
		logic [6:0] sh;
		sh = `LLSF_SHIFT_BASE + 7'(({2'h0, idx} * 7'h05) / 7'h03);
		if (sh > `LLSF_SHIFT_CAP) begin
			sh = `LLSF_SHIFT_CAP;
		end
		shift_of = sh[4:0];
	endfunction

	function automatic logic [15:0] absv(input logic signed [15:0] v);
		absv = v[15] ? 16'(-v) : v;
	endfunction

	// ======================================================================
	// Derived values
	logic [31:0] det_freq;
	logic [7:0] res_eff;
	logic [7:0] exp_max;
	logic [8:0] gain;
	logic [4:0] tc_min;
	logic sync_on;
	logic wr_go;
	logic rd_go;

	// Detection frequency in mHz.
	assign det_freq = {8'h00, ref_freq_i} * {24'h00_0000, s.harm};
	assign sync_on = s.sync_mode && !s.high;
	assign exp_max = (s.xexp > s.yexp) ? s.xexp : s.yexp;

	// In max and min modes the reserve follows the limits of the sensitivity.
	always_comb begin
		unique case (s.mode)
			LLSF_RES_MIN: res_eff = s.lim_min;
			LLSF_RES_MAN: res_eff = s.reserve;
			default: res_eff = s.lim_max;
		endcase
	end

	assign gain = {1'b0, res_eff} + {1'b0, exp_max};
	assign tc_min = min_tc(gain, s.slope);

	// One wait state: the request is seen, then answered on the next edge.
	assign wr_go = av_req_i.write && s.ack;
	assign rd_go = av_req_i.read && !s.ack;

	// ======================================================================
	// Filter chain
	logic [4:0] sh_set;
	logic [4:0] sh_min;
	logic [3:0][4:0] sh;
	logic [3:0] pv;
	llsf_xy_t [3:0] pd;

	assign sh_set = shift_of(s.tc);
	assign sh_min = shift_of(tc_min);

	// Poles nearest the detectors take the set time constant.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sh[i] = (2'(i) <= s.slope) ? sh_set : sh_min;
		end
	end

	llsf_pole u_pole0 (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.valid_i(in_valid_i),
		.shift_i(sh[0]),
		.din_i(phase_detector_i),
		.valid_o(pv[0]),
		.dout_o(pd[0])
	);

	llsf_pole u_pole1 (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.valid_i(pv[0]),
		.shift_i(sh[1]),
		.din_i(pd[0]),
		.valid_o(pv[1]),
		.dout_o(pd[1])
	);

	// The period filter, when active, sits between the second and third poles.
	llsf_pole u_pole2 (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.valid_i(s.mid_v),
		.shift_i(sh[2]),
		.din_i(s.mid),
		.valid_o(pv[2]),
		.dout_o(pd[2])
	);

	llsf_pole u_pole3 (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.valid_i(pv[2]),
		.shift_i(sh[3]),
		.din_i(pd[2]),
		.valid_o(pv[3]),
		.dout_o(pd[3])
	);

	// ======================================================================
	// Next state
	always_comb begin
		logic [7:0] v8;
		logic [8:0] off;
		logic [4:0] mt;
		logic [7:0] nx;
		logic [7:0] ny;
		logic [8:0] ng;
		logic [15:0] ax;
		logic [15:0] ay;
		logic signed [22:0] in_x;
		logic signed [22:0] in_y;
		v8 = 8'h00;
		off = 9'h000;
		mt = 5'h00;
		nx = 8'h00;
		ny = 8'h00;
		ng = 9'h000;
		ax = 16'h0000;
		ay = 16'h0000;
		in_x = 23'h00_0000;
		in_y = 23'h00_0000;
		next_s = s;

		// Bus handshake and read data.
		next_s.ack = (av_req_i.read || av_req_i.write) && !s.ack;
		if (rd_go) begin
			unique case (av_req_i.address)
				`LLSF_REG_CTRL: next_s.rdata = {27'h000_0000, s.sync_mode, s.slope, s.mode};
				`LLSF_REG_RES: next_s.rdata = {24'h00_0000, res_eff};
				`LLSF_REG_TC: next_s.rdata = {27'h000_0000, s.tc};
				`LLSF_REG_EXP: next_s.rdata = {16'h0000, s.yexp, s.xexp};
				`LLSF_REG_HARM: next_s.rdata = {24'h00_0000, s.harm};
				`LLSF_REG_STAT: next_s.rdata = {7'h00, gain, res_eff, 1'b0, tc_min, sync_on, s.high};
				`LLSF_REG_TRACE: next_s.rdata = s.trace;
				`LLSF_REG_MAG: next_s.rdata = {16'h0000, s.mag};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end

		// Sensitivity limits are tracked every cycle; the old minimum sets the offset.
		next_s.lim_min = res_min_i;
		next_s.lim_max = res_max_i;
		if (sens_chg_i && s.mode == LLSF_RES_MAN) begin
			off = {1'b0, s.reserve} - {1'b0, s.lim_min};
			off = off + {1'b0, res_min_i};
			next_s.reserve = (off > {1'b0, res_max_i}) ? res_max_i : off[7:0];
		end

		// Register writes.
		if (wr_go) begin
			unique case (av_req_i.address)
				`LLSF_REG_CTRL: begin
					if (av_req_i.writedata[`LLSF_CTRL_MODE_LO +: 2] != 2'h3) begin
						next_s.mode = llsf_resmode_t'(av_req_i.writedata[`LLSF_CTRL_MODE_LO +: 2]);
					end
					if (next_s.mode == LLSF_RES_MAN && s.mode != LLSF_RES_MAN) begin
						next_s.reserve = res_eff;
					end
					next_s.slope = av_req_i.writedata[`LLSF_CTRL_SLOPE_LO +: 2];
					next_s.sync_mode = av_req_i.writedata[`LLSF_CTRL_SYNC];
					if (av_req_i.writedata[`LLSF_CTRL_AUTO]) begin
						next_s.mode = LLSF_RES_MAN;
						v8 = res_safe_i;
						if (v8 < res_min_i) begin
							v8 = res_min_i;
						end
						if (v8 > res_max_i) begin
							v8 = res_max_i;
						end
						next_s.reserve = v8;
					end
				end
				`LLSF_REG_RES: begin
					v8 = av_req_i.writedata[7:0];
					if (s.mode == LLSF_RES_MAN && v8 >= res_min_i && v8 <= res_max_i
						&& ((v8 - res_min_i) % `LLSF_RES_STEP) == 8'h00) begin
						next_s.reserve = v8;
					end
				end
				`LLSF_REG_TC: begin
					mt = av_req_i.writedata[4:0];
					if (av_req_i.writedata[31:5] == 27'h000_0000 && mt >= tc_min
						&& mt <= (s.high ? `LLSF_TC_MAX_HI : `LLSF_TC_MAX_LO)) begin
						next_s.tc = mt;
					end
				end
				`LLSF_REG_EXP: begin
					nx = av_req_i.writedata[7:0];
					ny = av_req_i.writedata[15:8];
					ng = {1'b0, res_eff} + {1'b0, (nx > ny) ? nx : ny};
					if (!((nx > s.xexp || ny > s.yexp) && min_tc(ng, s.slope) > s.tc)) begin
						next_s.xexp = nx;
						next_s.yexp = ny;
					end
				end
				`LLSF_REG_HARM: begin
					if (av_req_i.writedata[7:0] != 8'h00) begin
						next_s.harm = av_req_i.writedata[7:0];
					end
				end
				default: begin
				end
			endcase
		end

		// Range hysteresis on the detection frequency.
		if (det_freq > `LLSF_FREQ_UP) begin
			next_s.high = 1'b1;
		end else if (det_freq < `LLSF_FREQ_DN) begin
			next_s.high = 1'b0;
		end

		// Time constant is the lowest priority: clamp after every other change.
		if (next_s.high && next_s.tc > `LLSF_TC_MAX_HI) begin
			next_s.tc = `LLSF_TC_MAX_HI;
		end
		{ax[8:0], ay[7:0]} = 17'h0_0000;
		ax[7:0] = (next_s.mode == LLSF_RES_MIN) ? res_min_i
			: (next_s.mode == LLSF_RES_MAN) ? next_s.reserve : res_max_i;
		ng = {1'b0, ax[7:0]} + {1'b0, (next_s.xexp > next_s.yexp) ? next_s.xexp : next_s.yexp};
		mt = min_tc(ng, next_s.slope);
		if (next_s.tc < mt) begin
			next_s.tc = mt;
		end

		// Period filter: replace the oldest slot and keep a running sum.
		if (sync_on) begin
			next_s.mid_v = slot_i;
			if (slot_i) begin
				in_x = 23'(pd[1].x);
				in_y = 23'(pd[1].y);
				next_s.sumx = s.sumx + in_x - 23'($signed(s.memx[s.ptr]));
				next_s.sumy = s.sumy + in_y - 23'($signed(s.memy[s.ptr]));
				next_s.memx[s.ptr] = pd[1].x;
				next_s.memy[s.ptr] = pd[1].y;
				next_s.ptr = s.ptr + 7'h01;
				next_s.mid = '{x: next_s.sumx[22:7], y: next_s.sumy[22:7]};
			end
		end else begin
			next_s.mid_v = pv[1];
			next_s.mid = pd[1];
		end

		// Slow path for traces and magnitude; X and Y outputs skip it.
		if (s.div == DIV_LAST) begin
			next_s.div = 32'h0000_0000;
			next_s.trace = pd[3];
			ax = absv(pd[3].x);
			ay = absv(pd[3].y);
			next_s.mag = (ax > ay) ? (ax + (ay >> 1)) : (ay + (ax >> 1));
		end else begin
			next_s.div = s.div + 32'h0000_0001;
		end
	end

	// ======================================================================
	// State register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= '0;
			s.harm <= `LLSF_RST_HARM;
			s.slope <= `LLSF_RST_SLOPE;
			s.tc <= `LLSF_RST_TC;
		end else begin
			s <= next_s;
		end
	end

	// ======================================================================
	// Outputs
	assign av_waitrequest_o = (av_req_i.read || av_req_i.write) && !s.ack;
	assign av_readdata_o = s.rdata;
	assign xy_o = pd[3];
	assign xy_valid_o = pv[3];
	assign trace_o = s.trace;
	assign mag_o = s.mag;
	assign sync_on_o = sync_on;
	assign tc_o = s.tc;
	assign reserve_o = res_eff;

endmodule

// >>> shared/llsf_defs.svh
// Register offsets, field positions, thresholds and timing counts of the lock-in output filter.
`ifndef LLSF_DEFS_SVH
`define LLSF_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define LLSF_REG_CTRL 5'h00
`define LLSF_REG_RES 5'h04
`define LLSF_REG_TC 5'h08
`define LLSF_REG_EXP 5'h0C
`define LLSF_REG_HARM 5'h10
`define LLSF_REG_STAT 5'h14
`define LLSF_REG_TRACE 5'h18
`define LLSF_REG_MAG 5'h1C

// ==========================================================================
// Control field positions
`define LLSF_CTRL_MODE_LO 0
`define LLSF_CTRL_SLOPE_LO 2
`define LLSF_CTRL_SYNC 4
`define LLSF_CTRL_AUTO 8

// ==========================================================================
// Reset values
`define LLSF_RST_HARM 8'h01
`define LLSF_RST_SLOPE 2'h0
`define LLSF_RST_TC 5'h08

// ==========================================================================
// Time constant indices in the 1-3-10 ladder, index 0 is 10 us.
`define LLSF_TC_MAX_HI 5'h0D
`define LLSF_TC_MAX_LO 5'h13
`define LLSF_TC_MIN_ABS 5'h00

// Range switch points in mHz: 203.12 Hz rising, 199.21 Hz falling.
`define LLSF_FREQ_UP 32'h0003_1970
`define LLSF_FREQ_DN 32'h0003_0A2A

// Reserve step in dB.
`define LLSF_RES_STEP 8'h0A

// Minimum time constant tables: first threshold, spacing, entries, in dB.
`define LLSF_MT1_BASE 9'h02D
`define LLSF_MT1_STEP 9'h00A
`define LLSF_MT1_N 5'h0D
`define LLSF_MT2_BASE 9'h037
`define LLSF_MT2_STEP 9'h014
`define LLSF_MT2_N 5'h06
`define LLSF_MT3_BASE 9'h03E
`define LLSF_MT3_STEP 9'h01E
`define LLSF_MT3_N 5'h04
`define LLSF_MT4_BASE 9'h048
`define LLSF_MT4_STEP 9'h028
`define LLSF_MT4_N 5'h03

// Pole coefficient shift: base plus five thirds per ladder step, capped.
`define LLSF_SHIFT_BASE 7'h02
`define LLSF_SHIFT_CAP 7'h18

// Period filter slots and slow update rate.
`define LLSF_SLOTS 128
`define LLSF_CLK_HZ 25000000
`define LLSF_TRACE_HZ 512

`endif

// >>> shared/llsf_pkg.sv
// Types shared by the lock-in output filter modules.
package llsf_pkg;

	// ======================================================================
	// Reserve modes; code 3 is illegal.
	typedef enum logic [1:0] {LLSF_RES_MAX, LLSF_RES_MIN, LLSF_RES_MAN} llsf_resmode_t;

	// ======================================================================
	// One X/Y sample pair.
	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
	} llsf_xy_t;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
	} llsf_av_req_t;

	// State of one low-pass pole.
	typedef struct packed {
		logic v;
		logic signed [39:0] ax;
		logic signed [39:0] ay;
	} llsf_pole_st_t;

	// State of the filter control block.
	typedef struct packed {
		llsf_resmode_t mode;
		logic [7:0] reserve;
		logic [7:0] lim_min;
		logic [7:0] lim_max;
		logic [4:0] tc;
		logic [1:0] slope;
		logic sync_mode;
		logic [7:0] harm;
		logic [7:0] xexp;
		logic [7:0] yexp;
		logic high;
		logic ack;
		logic [31:0] rdata;
		logic [31:0] div;
		llsf_xy_t trace;
		logic [15:0] mag;
		logic [127:0][15:0] memx;
		logic [127:0][15:0] memy;
		logic [6:0] ptr;
		logic signed [22:0] sumx;
		logic signed [22:0] sumy;
		llsf_xy_t mid;
		logic mid_v;
	} llsf_state_t;

endpackage
